/* File: rtl/refresh_tick_gen.sv */
`default_nettype none

module refresh_tick_gen #(
  parameter int unsigned PERIOD_CYCLES = srq_status_pkg::REFRESH_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  output var  logic tick_r
);
  import srq_status_pkg::*;

  localparam int unsigned CNT_W = (PERIOD_CYCLES > 2) ? $clog2(PERIOD_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD_CYCLES - 1);

  if (PERIOD_CYCLES < 2)
  begin : g_bad_period
    $error("refresh_tick_gen: PERIOD_CYCLES must be at least 2");
  end

  logic [CNT_W-1:0] cnt_r;

  // Free-running divider; one-cycle enable at the end of each period
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end
    else if (cnt_r == CNT_LAST)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + CNT_W'(1);
      tick_r <= 1'b0;
    end
  end

endmodule // refresh_tick_gen

`default_nettype wire

/* File: rtl/service_request_status_byte.sv */
`default_nettype none

// Overview of operation
// (R1) Errors or key raise request line, indicator
// (R2) Serial poll returns one eight-bit status byte
// (R3) Upper four bits are independent flags
// (R4) Lower four bits are one encoded code
// (R5) Top bit shows halted state, periodically refreshed
// (R6) Bit four shows running state, periodically refreshed
// (R7) Codes zero to seven: key, parse errors
// (R8) Codes eight to fifteen: hardware, setup errors
// (R9) Timing/level error sets hardware flag plus code
// (R10) Hardware flag holds while incompatibility persists
// (R11) Only latest error code kept, overwritten
// (R12) Poll does not clear code or the other flags
// (R13) Request flag marks new status since report
// (R14) Mask command silences request for 13, 14
// (R15) Request line held until serial poll
// (R16) Controller waits about 0.1 s before polling
// (R17) Controller polls all, finds request flag
// (R18) Only first error of a line reported
// (R19) Poll releases request line and flag
module service_request_status_byte #(
  parameter int unsigned REFRESH_CYCLES = srq_status_pkg::REFRESH_CYCLES
) (
  input  wire logic                              ref_clk,
  input  wire logic                              resetn,
  input  wire logic                              error_strobe,
  input  wire srq_status_pkg::err_code_t         error_code,
  input  wire logic                              line_end,
  input  wire logic                              key_pin,
  input  wire logic                              gen_running,
  input  wire logic                              gen_halted,
  input  wire logic                              screen_refresh_command,
  input  wire logic                              error_report_mask_command,
  input  wire logic [srq_status_pkg::MASK_ARG_W-1:0] mask_argument,
  input  wire logic                              timing_err_present,
  input  wire logic                              level_err_present,
  input  wire logic                              serial_poll_call,
  output var  logic                              service_request_r,
  output var  logic                              request_indicator_r,
  output var  srq_status_pkg::status_t           status_byte_r,
  output var  logic                              status_byte_valid_r
);
  import srq_status_pkg::*;

  logic       key_meta_r;
  logic       key_sync_r;
  logic       key_prev_r;
  logic       line_err_seen_r;
  mask_mode_e mask_mode_r;
  err_code_t  code_r;
  logic       hw_flag_r;
  logic       rqs_flag_r;
  logic       run_flag_r;
  logic       break_flag_r;
  logic       refresh_tick;

  logic       key_event;
  logic       err_accept;
  logic       load_event;
  logic       compat_event;
  logic       report_event;
  logic       compat_present;
  err_code_t  code_nxt;
  status_t    status_nxt;

  // Periodic refresh enable for the run and break flags
  refresh_tick_gen #(
    .PERIOD_CYCLES (REFRESH_CYCLES)
  ) u_refresh (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick_r  (refresh_tick)
  );

  // Front-panel key is asynchronous; two flops before any logic looks at it
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      key_meta_r <= 1'b0;
      key_sync_r <= 1'b0;
      key_prev_r <= 1'b0;
    end
    else
    begin
      key_meta_r <= key_pin;
      key_sync_r <= key_meta_r;
      key_prev_r <= key_sync_r;
    end
  end

  // Event decode; a key press loads code zero, a line error loads its own code
  always_comb
  begin
    key_event      = key_sync_r & ~key_prev_r;                          // [R1]
    err_accept     = error_strobe & ~line_err_seen_r;                   // [R18]
    load_event     = err_accept | key_event;
    compat_event   = err_accept & is_compat_code(error_code);           // [R9]
    compat_present = timing_err_present | level_err_present;
    // Masked incompatibility codes still load, but stay silent
    report_event   = key_event
                   | (err_accept
                      & ~((mask_mode_r == REPORT_MASKED)
                          & is_compat_code(error_code)));               // [R14]
    // A parser error beats a key press landing in the same cycle
    code_nxt       = err_accept ? error_code : CODE_USER_KEY;           // [R7] [R8]
  end

  // Snapshot of the live status; flags in the top nibble, code in the low one
  always_comb
  begin
    status_nxt            = STATUS_RESET;
    status_nxt[BIT_BREAK] = break_flag_r;                               // [R3]
    status_nxt[BIT_RQS]   = rqs_flag_r;                                 // [R3]
    status_nxt[BIT_HW]    = hw_flag_r;                                  // [R3]
    status_nxt[BIT_RUN]   = run_flag_r;                                 // [R3]
    status_nxt[CODE_W-1:0] = code_r;                                    // [R4]
  end

  // First error of a programming line wins; the line end re-arms capture
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      line_err_seen_r <= 1'b0;
    end
    else if (line_end)
    begin
      line_err_seen_r <= 1'b0;                                          // [R18]
    end
    else if (err_accept)
    begin
      line_err_seen_r <= 1'b1;                                          // [R18]
    end
  end

  // Mask mode; any other argument value leaves the mode alone
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      mask_mode_r <= REPORT_ALL;
    end
    else if (error_report_mask_command)
    begin
      if (mask_argument == MASK_ARG_SUPPRESS)
      begin
        mask_mode_r <= REPORT_MASKED;                                   // [R14]
      end
      else if (mask_argument == MASK_ARG_RESTORE)
      begin
        mask_mode_r <= REPORT_ALL;                                      // [R14]
      end
    end
  end

  // Single level of reporting: newest code overwrites, nothing is queued
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      code_r <= CODE_RESET;
    end
    else if (load_event)
    begin
      code_r <= code_nxt;                                               // [R11]
    end
  end

  // Hardware flag survives later codes while an incompatibility persists;
  // it only drops when a new code (error or key press) loads and no such condition remains
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      hw_flag_r <= 1'b0;
    end
    else if (compat_event)
    begin
      hw_flag_r <= 1'b1;                                                // [R9] [R14]
    end
    else if (load_event && !compat_present)
    begin
      hw_flag_r <= 1'b0;                                                // [R10]
    end
  end

  // Request flag and line; a new report in the poll cycle keeps them set
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      rqs_flag_r          <= 1'b0;
      service_request_r   <= 1'b0;
      request_indicator_r <= 1'b0;
    end
    else if (report_event)
    begin
      rqs_flag_r          <= 1'b1;                                      // [R13]
      service_request_r   <= 1'b1;                                      // [R1] [R15]
      request_indicator_r <= 1'b1;                                      // [R1]
    end
    else if (serial_poll_call)
    begin
      rqs_flag_r          <= 1'b0;                                      // [R19]
      service_request_r   <= 1'b0;                                      // [R19]
      request_indicator_r <= 1'b0;                                      // [R19]
    end
  end

  // Run and break sampled only on refresh, so they may lag the generator
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      run_flag_r   <= 1'b0;
      break_flag_r <= 1'b0;
    end
    else if (refresh_tick || screen_refresh_command)
    begin
      run_flag_r   <= gen_running;                                      // [R6]
      break_flag_r <= gen_halted;                                       // [R5]
    end
  end

  // Poll answer: byte captured before the poll clears the request flag
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      status_byte_r       <= STATUS_RESET;
      status_byte_valid_r <= 1'b0;
    end
    else
    begin
      status_byte_valid_r <= serial_poll_call;                          // [R2] [R15]
      if (serial_poll_call)
      begin
        status_byte_r <= status_nxt;                                    // [R2] [R12]
      end
    end
  end

endmodule // service_request_status_byte

`default_nettype wire

/* File: shared/srq_status_pkg.sv */
`default_nettype none

package srq_status_pkg;

  // Clock and status refresh timing
  localparam int unsigned CLK_FREQ_HZ       = 200_000_000;
  localparam int unsigned REFRESH_PERIOD_MS = 50;
  localparam int unsigned REFRESH_CYCLES    = (CLK_FREQ_HZ / 1000) * REFRESH_PERIOD_MS;

  // Status byte layout
  localparam int unsigned STATUS_W  = 8;
  localparam int unsigned CODE_W    = 4;
  localparam int unsigned BIT_BREAK = 7;
  localparam int unsigned BIT_RQS   = 6;
  localparam int unsigned BIT_HW    = 5;
  localparam int unsigned BIT_RUN   = 4;

  typedef logic [CODE_W-1:0]   err_code_t;
  typedef logic [STATUS_W-1:0] status_t;

  // Encoded message values of the low nibble
  localparam err_code_t CODE_USER_KEY       = 4'h0;
  localparam err_code_t CODE_SYNTAX         = 4'h1;
  localparam err_code_t CODE_UNEXP_UNIT     = 4'h2;
  localparam err_code_t CODE_INCOMPLETE     = 4'h3;
  localparam err_code_t CODE_UNTERM_STRING  = 4'h4;
  localparam err_code_t CODE_RANGE_OVERFLOW = 4'h5;
  localparam err_code_t CODE_ILLEGAL_SIGN   = 4'h6;
  localparam err_code_t CODE_ILLEGAL_UNIT   = 4'h7;
  localparam err_code_t CODE_HW_ABSENT      = 4'h8;
  localparam err_code_t CODE_ILLEGAL_CHAN   = 4'h9;
  localparam err_code_t CODE_ENTRY_DENIED   = 4'hA;
  localparam err_code_t CODE_FORMATTER      = 4'hB;
  localparam err_code_t CODE_PARAM_LOST     = 4'hC;
  localparam err_code_t CODE_TIMING         = 4'hD;
  localparam err_code_t CODE_LEVEL          = 4'hE;
  localparam err_code_t CODE_TRIGGER_LATE   = 4'hF;

  // Mask command arguments
  localparam int unsigned MASK_ARG_W      = 2;
  localparam logic [1:0]  MASK_ARG_RESTORE = 2'h1;
  localparam logic [1:0]  MASK_ARG_SUPPRESS = 2'h2;

  // Reset values
  localparam err_code_t CODE_RESET   = 4'h0;
  localparam status_t   STATUS_RESET = 8'h00;

  typedef enum logic
  {
    REPORT_ALL    = 1'b0,
    REPORT_MASKED = 1'b1
  } mask_mode_e;

  // Timing or level incompatibility code
  function automatic logic is_compat_code(input err_code_t code);
    return (code == CODE_TIMING) || (code == CODE_LEVEL);
  endfunction

endpackage

`default_nettype wire

/* File: testbench/poll_controller_model.sv */
`default_nettype none
module poll_controller_model #(
  parameter int unsigned WAIT_CYCLES = 20
) (
  input wire logic  ref_clk,
  input wire logic  auto_en,
  input wire logic  poll_now,
  input wire logic  service_request_r,
  output var logic  serial_poll_call
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_r = 0;
  logic        fire_r = 1'b0;
  // Waits after the request before polling so the run and break flags refresh
  // Sole instrument on the bus, so the request line names it
  always @(negedge ref_clk)
  begin
    fire_r <= auto_en && service_request_r && wait_r == WAIT_CYCLES;
    wait_r <= (auto_en && service_request_r && !fire_r) ? wait_r + 1 : 0;
  end
  assign serial_poll_call = poll_now | fire_r;
endmodule // poll_controller_model
`default_nettype wire

/* File: testbench/service_request_status_byte_tb.sv */
`default_nettype none
module service_request_status_byte_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import srq_status_pkg::*;
  logic      ref_clk = 0, resetn = 0, error_strobe = 0, line_end = 0, key_pin = 0;
  logic      gen_running = 0, gen_halted = 0, screen_refresh_command = 0;
  logic      error_report_mask_command = 0, timing_err_present = 0, level_err_present = 0;
  logic      auto_en = 0, poll_now = 0, serial_poll_call, service_request_r;
  logic      request_indicator_r, status_byte_valid_r, e_hw = 0, e_run = 0, e_brk = 0;
  logic [1:0] mask_argument = 2'h0;
  err_code_t error_code = 4'h0, e_code = 4'h0;
  status_t   status_byte_r;
  int        n_mismatch = 0, samples_checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  service_request_status_byte #(
    .REFRESH_CYCLES (16)
  ) service_request_status_byte_inst (
    .ref_clk                   (ref_clk),
    .resetn                    (resetn),
    .error_strobe              (error_strobe),
    .error_code                (error_code),
    .line_end                  (line_end),
    .key_pin                   (key_pin),
    .gen_running               (gen_running),
    .gen_halted                (gen_halted),
    .screen_refresh_command    (screen_refresh_command),
    .error_report_mask_command (error_report_mask_command),
    .mask_argument             (mask_argument),
    .timing_err_present        (timing_err_present),
    .level_err_present         (level_err_present),
    .serial_poll_call          (serial_poll_call),
    .service_request_r         (service_request_r),
    .request_indicator_r       (request_indicator_r),
    .status_byte_r             (status_byte_r),
    .status_byte_valid_r       (status_byte_valid_r)
  );
  poll_controller_model poll_controller_model_inst (
    .ref_clk           (ref_clk),
    .auto_en           (auto_en),
    .poll_now          (poll_now),
    .service_request_r (service_request_r),
    .serial_poll_call  (serial_poll_call)
  );
  function automatic status_t exp_byte(input logic rqs);
    return {e_brk, rqs, e_hw, e_run, e_code};
  endfunction
  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_byte(input string what, input status_t exp, input status_t got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pulse helpers drive on the falling edge, away from sampling
  task automatic send_error(input err_code_t c, input logic le);
    @(negedge ref_clk);
    error_strobe = 1;
    error_code = c;
    line_end = le;
    @(negedge ref_clk);
    error_strobe = 0;
    line_end = 0;
  endtask
  task automatic pulse_mask(input logic [1:0] arg);
    @(negedge ref_clk);
    error_report_mask_command = 1;
    mask_argument = arg;
    @(negedge ref_clk);
    error_report_mask_command = 0;
  endtask
  task automatic refresh(input logic run);
    @(negedge ref_clk);
    gen_running = run;
    gen_halted = !run;
    screen_refresh_command = 1;
    e_run = run;
    e_brk = !run;
    @(negedge ref_clk);
    screen_refresh_command = 0;
  endtask
  // Caller sits on a falling edge; the valid pulse stands one cycle only,
  // so the answer is read at the very next falling edge
  task automatic poll(input logic rqs);
    poll_now = 1;
    @(negedge ref_clk);
    poll_now = 0;
    check_bit("valid", 1'b1, status_byte_valid_r);
    check_byte("status", exp_byte(rqs), status_byte_r);
    check_bit("released", 1'b0, service_request_r);
    @(negedge ref_clk);
  endtask
  task automatic tally_and_finish;
    $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(97328));
    repeat (12) @(negedge ref_clk);
    resetn = 1;
    poll(1'b0);
    // Every code once, run or break drawn at random
    for (int i = 0; i < 16; i++)
    begin
      refresh(1'($urandom_range(1)));
      send_error(i[3:0], 1'b1);
      e_code = i[3:0];
      e_hw = (i == 13 || i == 14);
      check_bit("request", 1'b1, service_request_r);
      check_bit("indicator", 1'b1, request_indicator_r);
      poll(1'b1);
      poll(1'b0);
    end
    // Second error of a line is dropped; line_end alongside it only re-arms
    send_error(CODE_SYNTAX, 1'b0);
    send_error(CODE_ILLEGAL_SIGN, 1'b1);
    e_code = CODE_SYNTAX;
    e_hw = 0;
    poll(1'b1);
    send_error(CODE_ILLEGAL_CHAN, 1'b1);
    send_error(CODE_ENTRY_DENIED, 1'b1);
    e_code = CODE_ENTRY_DENIED;
    poll(1'b1);
    // Hardware flag outlives a newer code while the fault persists
    timing_err_present = 1;
    send_error(CODE_TIMING, 1'b1);
    send_error(CODE_SYNTAX, 1'b1);
    e_code = CODE_SYNTAX;
    e_hw = 1;
    poll(1'b1);
    timing_err_present = 0;
    pulse_mask(MASK_ARG_SUPPRESS);
    // An unknown argument must leave the masked mode alone
    pulse_mask(2'h3);
    send_error(CODE_LEVEL, 1'b1);
    check_bit("masked", 1'b0, service_request_r);
    e_code = CODE_LEVEL;
    poll(1'b0);
    pulse_mask(MASK_ARG_RESTORE);
    send_error(CODE_TIMING, 1'b1);
    check_bit("restored", 1'b1, service_request_r);
    e_code = CODE_TIMING;
    poll(1'b1);
    // Key press answered by the controller model's own delayed poll
    auto_en = 1;
    key_pin = 1;
    e_code = CODE_USER_KEY;
    e_hw = 0;
    for (int k = 0; k < 60 && status_byte_valid_r !== 1'b1; k++) @(negedge ref_clk);
    check_bit("auto poll", 1'b1, status_byte_valid_r);
    check_byte("key status", exp_byte(1'b1), status_byte_r);
    auto_en = 0;
    key_pin = 0;
    tally_and_finish;
  end
endmodule // service_request_status_byte_tb
bind service_request_status_byte srq_status_properties srq_status_properties_inst (
  .ref_clk                   (ref_clk),
  .resetn                    (resetn),
  .error_strobe              (error_strobe),
  .error_code                (error_code),
  .line_end                  (line_end),
  .key_pin                   (key_pin),
  .error_report_mask_command (error_report_mask_command),
  .mask_argument             (mask_argument),
  .serial_poll_call          (serial_poll_call),
  .service_request_r         (service_request_r),
  .request_indicator_r       (request_indicator_r),
  .status_byte_r             (status_byte_r),
  .status_byte_valid_r       (status_byte_valid_r)
);
`default_nettype wire

/* File: testbench/srq_status_properties.sv */
`default_nettype none
module srq_status_properties (
  input wire logic                      ref_clk,
  input wire logic                      resetn,
  input wire logic                      error_strobe,
  input wire srq_status_pkg::err_code_t error_code,
  input wire logic                      line_end,
  input wire logic                      key_pin,
  input wire logic                      error_report_mask_command,
  input wire logic [1:0]                mask_argument,
  input wire logic                      serial_poll_call,
  input wire logic                      service_request_r,
  input wire logic                      request_indicator_r,
  input wire srq_status_pkg::status_t   status_byte_r,
  input wire logic                      status_byte_valid_r
);
  timeunit 1ns;
  timeprecision 1ps;
  import srq_status_pkg::*;
  logic       armed_r, masked_r, acc, compat, key_quiet;
  logic [2:0] key_hist_r;
  assign compat = (error_code == CODE_TIMING) || (error_code == CODE_LEVEL);
  assign acc = error_strobe && armed_r;
  assign key_quiet = !key_pin && (key_hist_r == 3'h0);
  // Line re-arms at its end, even when an error shares that cycle
  always_ff @(posedge ref_clk)
    if (!resetn || line_end) armed_r <= 1'b1;
    else if (error_strobe) armed_r <= 1'b0;
  // Mask mode as the device should hold it
  always_ff @(posedge ref_clk)
    if (!resetn) masked_r <= 1'b0;
    else if (error_report_mask_command && mask_argument == MASK_ARG_SUPPRESS) masked_r <= 1'b1;
    else if (error_report_mask_command && mask_argument == MASK_ARG_RESTORE) masked_r <= 1'b0;
  // Key history covers the synchroniser delay
  always_ff @(posedge ref_clk)
    key_hist_r <= {key_hist_r[1:0], key_pin};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_req_on_error: assert property (acc && !(masked_r && compat) |=> service_request_r)
    else $error("no request after error");
  a_indicator_match: assert property (request_indicator_r == service_request_r)
    else $error("indicator differs from request line");
  a_poll_answer: assert property (serial_poll_call |=> status_byte_valid_r)
    else $error("poll not answered");
  a_valid_cause: assert property (status_byte_valid_r |-> $past(serial_poll_call))
    else $error("byte valid without poll");
  a_byte_hold: assert property (!status_byte_valid_r |-> $stable(status_byte_r))
    else $error("status byte changed without poll");
  a_rqs_reported: assert property (status_byte_valid_r |->
    status_byte_r[BIT_RQS] == $past(service_request_r)) else $error("request bit wrong");
  a_compat_flag: assert property (acc && compat ##1 serial_poll_call |=>
    status_byte_r[BIT_HW] && status_byte_r[3:0] == $past(error_code, 2))
    else $error("compat error not flagged");
  a_req_holds: assert property (service_request_r && !serial_poll_call |=> service_request_r)
    else $error("request dropped before poll");
  a_poll_releases: assert property (serial_poll_call && !error_strobe && key_quiet
    |=> !service_request_r) else $error("request kept after poll");
  a_mask_silent: assert property (masked_r && acc && compat && !service_request_r
    && key_quiet |=> !service_request_r) else $error("masked code raised request");
  cover property (acc ##1 serial_poll_call);
  cover property (masked_r && acc && compat);
  cover property (serial_poll_call ##1 serial_poll_call);
endmodule // srq_status_properties
`default_nettype wire
